// ---- shared/cbd_pkg.sv ----
package cbd_pkg;
    // command codes
    localparam logic [15:0] CMD_OUTPUT_ON_OFF   = 16'h0000;
    localparam logic [15:0] CMD_CHARGE_V_SET    = 16'h0020;
    localparam logic [15:0] CMD_CHARGE_I_SET    = 16'h0030;
    localparam logic [15:0] CMD_FAULT_FLAGS     = 16'h0040;
    localparam logic [15:0] CMD_AC_V_READ       = 16'h0050;
    localparam logic [15:0] CMD_DC_V_READ       = 16'h0060;
    localparam logic [15:0] CMD_DC_I_READ       = 16'h0061;
    localparam logic [15:0] CMD_TEMP_READ       = 16'h0062;
    localparam logic [15:0] CMD_FAN1_READ       = 16'h0070;
    localparam logic [15:0] CMD_FAN2_READ       = 16'h0071;
    localparam logic [15:0] CMD_MAKER_FIRST     = 16'h0080;
    localparam logic [15:0] CMD_MAKER_LAST      = 16'h0081;
    localparam logic [15:0] CMD_MODEL_FIRST     = 16'h0082;
    localparam logic [15:0] CMD_MODEL_LAST      = 16'h0083;
    localparam logic [15:0] CMD_FW_REVISIONS    = 16'h0084;
    localparam logic [15:0] CMD_FACTORY_LOC     = 16'h0085;
    localparam logic [15:0] CMD_BUILD_DATE      = 16'h0086;
    localparam logic [15:0] CMD_SERIAL_FIRST    = 16'h0087;
    localparam logic [15:0] CMD_SERIAL_LAST     = 16'h0088;
    localparam logic [15:0] CMD_UNIT_MULT       = 16'h00c0;
    localparam logic [15:0] CMD_STATE_WORD      = 16'h00c1;
    localparam logic [15:0] CMD_SETTINGS        = 16'h00c2;
    localparam logic [15:0] CMD_FLOW_DIR        = 16'h0100;
    localparam logic [15:0] CMD_DISCHARGE_V_SET = 16'h0120;
    localparam logic [15:0] CMD_DISCHARGE_I_SET = 16'h0130;
    localparam logic [15:0] CMD_TWO_WAY_SETUP   = 16'h0140;

    // frame identifiers, 29 bits = prefix & unit byte
    localparam logic [20:0] ID_REQ_PREFIX = 21'h000c03;
    localparam logic [20:0] ID_RSP_PREFIX = 21'h000c02;
    localparam logic [7:0]  ID_BROADCAST  = 8'hff;

    // payload lengths in bytes
    localparam logic [3:0] DLC_CMD  = 4'h2;
    localparam logic [3:0] LEN_BYTE = 4'h1;
    localparam logic [3:0] LEN_WORD = 4'h2;
    localparam logic [3:0] LEN_LOC  = 4'h3;
    localparam logic [3:0] LEN_STR  = 4'h6;

    // fault word bit positions
    localparam int FLT_FAN_LOCKED = 0;
    localparam int FLT_OVER_TEMP  = 1;
    localparam int FLT_DC_OV      = 2;
    localparam int FLT_DC_OC      = 3;
    localparam int FLT_SHORT      = 4;
    localparam int FLT_AC_RANGE   = 5;
    localparam int FLT_DC_OFF     = 6;
    localparam int FLT_HIGH_TEMP  = 7;
    localparam int FLT_HV_OV      = 8;

    // multiplier codes and the reported word
    localparam logic [3:0]  SCALE_0P01       = 4'h5;
    localparam logic [3:0]  SCALE_0P1        = 4'h6;
    localparam logic [3:0]  SCALE_1          = 4'h7;
    localparam logic [15:0] UNIT_MULTIPLIERS = {SCALE_1, SCALE_0P1, SCALE_0P01, SCALE_0P01};

    // settings word fields
    localparam int         CFG_NV_OFF_BIT = 10;
    localparam int         CFG_NV_DLY_LSB = 8;
    localparam logic [1:0] NV_DLY_NOW     = 2'b00;
    localparam logic [1:0] NV_DLY_1MIN    = 2'b01;
    localparam logic [1:0] NV_DLY_10MIN   = 2'b10;

    // legal one-byte values
    localparam logic [7:0] OUT_OFF      = 8'h00;
    localparam logic [7:0] OUT_ON       = 8'h01;
    localparam logic [7:0] DIR_AC_TO_DC = 8'h00;
    localparam logic [7:0] DIR_DC_TO_AC = 8'h01;

    // values after reset
    localparam logic [7:0]  RST_BYTE = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [23:0] RST_LOC  = 24'h202020;
    localparam logic [47:0] RST_STR  = 48'h202020202020;

    // timing
    localparam int CLK_MHZ        = 25;
    localparam int TICK_US        = 1000;
    localparam int TICK_CYCLES    = TICK_US * CLK_MHZ;
    localparam int NV_DELAY1_MS   = 60000;
    localparam int NV_DELAY10_MS  = 600000;

    // identity defaults, arbitrary values
    localparam logic [47:0] ID_MAKER_FIRST = 48'h4f5254585953;
    localparam logic [47:0] ID_MAKER_LAST  = 48'h202020205950;
    localparam logic [47:0] ID_MODEL_FIRST = 48'h363738395850;
    localparam logic [47:0] ID_MODEL_LAST  = 48'h202020205135;
    localparam logic [47:0] ID_FW_REVS     = 48'hffffffff1a0a;
endpackage

// ---- shared/cbd_lookup_if.sv ----
`timescale 1ns/1ps
interface cbd_lookup_if;
    logic [15:0] code;
    logic        known;
    logic        writable;
    logic        nv_gated;
    logic [3:0]  nbytes;

    modport req  (output code, input known, writable, nv_gated, nbytes);
    modport resp (input code, output known, writable, nv_gated, nbytes);
endinterface

// ---- core/cbd_cmd_lookup.sv ----
`timescale 1ns/1ps
module cbd_cmd_lookup
    import cbd_pkg::*;
(
    // command attributes
    cbd_lookup_if.resp lk
);
    always_comb
    begin
        lk.known    = 1'b1;
        lk.writable = 1'b0;
        lk.nv_gated = 1'b0;
        lk.nbytes   = LEN_WORD;
        if (lk.code == CMD_OUTPUT_ON_OFF || lk.code == CMD_FLOW_DIR)
        begin
            lk.writable = 1'b1;
            lk.nbytes   = LEN_BYTE;
        end
        else if (lk.code == CMD_CHARGE_V_SET || lk.code == CMD_CHARGE_I_SET
                 || lk.code == CMD_DISCHARGE_V_SET || lk.code == CMD_DISCHARGE_I_SET)
        begin
            lk.writable = 1'b1;
            lk.nv_gated = 1'b1;
        end
        else if (lk.code == CMD_SETTINGS || lk.code == CMD_TWO_WAY_SETUP)
            lk.writable = 1'b1;
        else if (lk.code == CMD_FACTORY_LOC)
        begin
            lk.writable = 1'b1;
            lk.nbytes   = LEN_LOC;
        end
        else if (lk.code == CMD_BUILD_DATE || lk.code == CMD_SERIAL_FIRST
                 || lk.code == CMD_SERIAL_LAST)
        begin
            lk.writable = 1'b1;
            lk.nbytes   = LEN_STR;
        end
        else if (lk.code == CMD_MAKER_FIRST || lk.code == CMD_MAKER_LAST
                 || lk.code == CMD_MODEL_FIRST || lk.code == CMD_MODEL_LAST
                 || lk.code == CMD_FW_REVISIONS)
            lk.nbytes = LEN_STR;
        else if (lk.code == CMD_FAULT_FLAGS || lk.code == CMD_AC_V_READ
                 || lk.code == CMD_DC_V_READ || lk.code == CMD_DC_I_READ
                 || lk.code == CMD_TEMP_READ || lk.code == CMD_FAN1_READ
                 || lk.code == CMD_FAN2_READ || lk.code == CMD_UNIT_MULT
                 || lk.code == CMD_STATE_WORD)
            lk.nbytes = LEN_WORD;
        else
            lk.known = 1'b0;
    end
endmodule

// ---- core/cbd_decoder.sv ----
`timescale 1ns/1ps
// Operation
// - physical value is raw bus integer times the command's multiplier
// - same multiplier for writing and reading; controller pre-scales writes
// - multipliers may differ per command; reported by command 0x00c0
// - fault bit 0 fan locked, bit 1 over-temperature
// - fault bit 2 dc over-voltage, bit 3 dc over-current
// - fault bit 4 short circuit, bit 5 ac out of range
// - fault bit 6 dc output off, bit 7 high-temperature alarm
// - fault high byte bit 0 hv-side over-voltage, rest zero
// - maker name as two six-byte ascii reads, space padded
// - model name as two six-byte ascii reads, space padded
// - revision reply one byte per processor, 0xff means not fitted
// - direction byte read/write: 00 ac-to-dc, 01 dc-to-ac
// - only the four setpoints honour nv disable and store delay
// - requests on 0x000c03 plus unit or ff; replies on 0x000c02 plus unit
// - no reply to an accepted write; only reads answered
// - all frames use the 29-bit extended identifier
// - bus runs at 250 kbit/s
module cbd_decoder
    import cbd_pkg::*;
#(
    parameter int          TICK_LEN     = TICK_CYCLES,
    parameter int          NV_1MIN_MS   = NV_DELAY1_MS,
    parameter int          NV_10MIN_MS  = NV_DELAY10_MS,
    parameter logic [47:0] MAKER_FIRST  = ID_MAKER_FIRST,
    parameter logic [47:0] MAKER_LAST   = ID_MAKER_LAST,
    parameter logic [47:0] MODEL_FIRST  = ID_MODEL_FIRST,
    parameter logic [47:0] MODEL_LAST   = ID_MODEL_LAST,
    parameter logic [47:0] FW_REVS      = ID_FW_REVS
)
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // unit number from the address switches
    input  wire logic [5:0]  unit_addr,
    // received frame; the bus controller owns the bit rate
    input  wire logic        rx_valid,
    input  wire logic        rx_ext,
    input  wire logic [28:0] rx_id,
    input  wire logic [3:0]  rx_dlc,
    input  wire logic [63:0] rx_data,
    // reply frame to the bus controller
    output logic             tx_valid,
    input  wire logic        tx_ready,
    output logic             tx_ext,
    output logic [28:0]      tx_id,
    output logic [3:0]       tx_dlc,
    output logic [63:0]      tx_data,
    // protection conditions from the power stage
    input  wire logic        fan_locked,
    input  wire logic        over_temp,
    input  wire logic        dc_overvoltage_flag,
    input  wire logic        dc_overcurrent_flag,
    input  wire logic        short_circuit,
    input  wire logic        ac_range_fault_flag,
    input  wire logic        dc_output_off_flag,
    input  wire logic        high_temperature_alarm,
    input  wire logic        hv_side_overvoltage_flag,
    // measurements and state from the power stage
    input  wire logic [15:0] ac_voltage_in,
    input  wire logic [15:0] dc_voltage_in,
    input  wire logic [15:0] dc_current_in,
    input  wire logic [15:0] ambient_temp_in,
    input  wire logic [15:0] fan1_speed_in,
    input  wire logic [15:0] fan2_speed_in,
    input  wire logic [15:0] system_state_in,
    // stored parameters toward the power stage
    output logic [7:0]       output_on_off,
    output logic [15:0]      charge_voltage_setpoint,
    output logic [15:0]      charge_current_setpoint,
    output logic [15:0]      discharge_voltage_setpoint,
    output logic [15:0]      discharge_current_setpoint,
    output logic [7:0]       power_flow_direction,
    output logic [15:0]      system_settings,
    output logic [15:0]      two_way_mode_setup,
    output logic [23:0]      factory_location,
    output logic [47:0]      build_date,
    output logic [47:0]      serial_number_first,
    output logic [47:0]      serial_number_last,
    // one-cycle request to commit parameters to non-volatile storage
    output logic             nv_save
);
    import cbd_pkg::*;

    cbd_lookup_if lk ();

    logic [15:0] fault_flags;
    logic [15:0] ac_voltage_reading;
    logic [15:0] dc_voltage_reading;
    logic [15:0] dc_current_reading;
    logic [15:0] ambient_temp_reading;
    logic [15:0] fan1_speed_reading;
    logic [15:0] fan2_speed_reading;
    logic [15:0] system_state_word;
    logic        addressed;
    logic        is_read;
    logic        is_write;
    logic        wr_fire;
    logic        rd_fire;
    logic [47:0] wr_value;
    logic [47:0] rd_value;
    logic [14:0] tick_cnt;
    logic        tick;
    logic        nv_pending;
    logic [19:0] nv_ms;
    logic [19:0] nv_limit;

    // zero every byte above the command's length
    function automatic logic [47:0] keep_bytes(input logic [47:0] v, input logic [3:0] n);
        logic [47:0] m;
        m = '0;
        for (int i = 0; i < 6; i++)
            if (4'(i) < n)
                m[i*8 +: 8] = 8'hff;
        return v & m;
    endfunction

    cbd_cmd_lookup u_lookup (
        .lk (lk)
    );

    // command code travels low byte first
    assign lk.code = rx_data[15:0];

    assign addressed = rx_valid && rx_ext
                       && rx_id[28:8] == ID_REQ_PREFIX
                       && (rx_id[7:0] == {2'b00, unit_addr} || rx_id[7:0] == ID_BROADCAST);
    assign is_read   = rx_dlc == DLC_CMD;
    assign is_write  = rx_dlc == DLC_CMD + lk.nbytes;
    // unknown codes and read-only targets fall out here
    assign wr_fire   = addressed && lk.known && lk.writable && is_write;
    assign rd_fire   = addressed && lk.known && is_read && !tx_valid;
    assign wr_value  = keep_bytes(rx_data[63:16], lk.nbytes);

    // readings captured every cycle so a reply is one coherent snapshot;
    // no reset needed, each cycle overwrites them and reads wait for release
    always_ff @(posedge sys_clk)
    begin
        fault_flags                 <= RST_WORD;
        fault_flags[FLT_FAN_LOCKED] <= fan_locked;
        fault_flags[FLT_OVER_TEMP]  <= over_temp;
        fault_flags[FLT_DC_OV]      <= dc_overvoltage_flag;
        fault_flags[FLT_DC_OC]      <= dc_overcurrent_flag;
        fault_flags[FLT_SHORT]      <= short_circuit;
        fault_flags[FLT_AC_RANGE]   <= ac_range_fault_flag;
        fault_flags[FLT_DC_OFF]     <= dc_output_off_flag;
        fault_flags[FLT_HIGH_TEMP]  <= high_temperature_alarm;
        fault_flags[FLT_HV_OV]      <= hv_side_overvoltage_flag;
        ac_voltage_reading          <= ac_voltage_in;
        dc_voltage_reading          <= dc_voltage_in;
        dc_current_reading          <= dc_current_in;
        ambient_temp_reading        <= ambient_temp_in;
        fan1_speed_reading          <= fan1_speed_in;
        fan2_speed_reading          <= fan2_speed_in;
        system_state_word           <= system_state_in;
    end

    // control parameters; raw integers kept as sent, scaling is the controller's
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            output_on_off              <= RST_BYTE;
            charge_voltage_setpoint    <= RST_WORD;
            charge_current_setpoint    <= RST_WORD;
            discharge_voltage_setpoint <= RST_WORD;
            discharge_current_setpoint <= RST_WORD;
            power_flow_direction       <= RST_BYTE;
            system_settings            <= RST_WORD;
            two_way_mode_setup         <= RST_WORD;
        end
        else if (wr_fire)
        begin
            // illegal one-byte values are dropped rather than stored
            if (lk.code == CMD_OUTPUT_ON_OFF)
            begin
                if (wr_value[7:0] == OUT_ON || wr_value[7:0] == OUT_OFF)
                    output_on_off <= wr_value[7:0];
            end
            else if (lk.code == CMD_FLOW_DIR)
            begin
                if (wr_value[7:0] == DIR_AC_TO_DC || wr_value[7:0] == DIR_DC_TO_AC)
                    power_flow_direction <= wr_value[7:0];
            end
            else if (lk.code == CMD_CHARGE_V_SET)
                charge_voltage_setpoint <= wr_value[15:0];
            else if (lk.code == CMD_CHARGE_I_SET)
                charge_current_setpoint <= wr_value[15:0];
            else if (lk.code == CMD_DISCHARGE_V_SET)
                discharge_voltage_setpoint <= wr_value[15:0];
            else if (lk.code == CMD_DISCHARGE_I_SET)
                discharge_current_setpoint <= wr_value[15:0];
            else if (lk.code == CMD_SETTINGS)
                system_settings <= wr_value[15:0];
            else if (lk.code == CMD_TWO_WAY_SETUP)
                two_way_mode_setup <= wr_value[15:0];
        end
    end

    // factory fields, rewritable
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            factory_location    <= RST_LOC;
            build_date          <= RST_STR;
            serial_number_first <= RST_STR;
            serial_number_last  <= RST_STR;
        end
        else if (wr_fire)
        begin
            if (lk.code == CMD_FACTORY_LOC)
                factory_location <= wr_value[23:0];
            else if (lk.code == CMD_BUILD_DATE)
                build_date <= wr_value;
            else if (lk.code == CMD_SERIAL_FIRST)
                serial_number_first <= wr_value;
            else if (lk.code == CMD_SERIAL_LAST)
                serial_number_last <= wr_value;
        end
    end

    // read selection
    always_comb
    begin
        rd_value = '0;
        if (lk.code == CMD_OUTPUT_ON_OFF)
            rd_value[7:0] = output_on_off;
        else if (lk.code == CMD_CHARGE_V_SET)
            rd_value[15:0] = charge_voltage_setpoint;
        else if (lk.code == CMD_CHARGE_I_SET)
            rd_value[15:0] = charge_current_setpoint;
        else if (lk.code == CMD_FAULT_FLAGS)
            rd_value[15:0] = fault_flags;
        else if (lk.code == CMD_AC_V_READ)
            rd_value[15:0] = ac_voltage_reading;
        else if (lk.code == CMD_DC_V_READ)
            rd_value[15:0] = dc_voltage_reading;
        else if (lk.code == CMD_DC_I_READ)
            rd_value[15:0] = dc_current_reading;
        else if (lk.code == CMD_TEMP_READ)
            rd_value[15:0] = ambient_temp_reading;
        else if (lk.code == CMD_FAN1_READ)
            rd_value[15:0] = fan1_speed_reading;
        else if (lk.code == CMD_FAN2_READ)
            rd_value[15:0] = fan2_speed_reading;
        else if (lk.code == CMD_MAKER_FIRST)
            rd_value = MAKER_FIRST;
        else if (lk.code == CMD_MAKER_LAST)
            rd_value = MAKER_LAST;
        else if (lk.code == CMD_MODEL_FIRST)
            rd_value = MODEL_FIRST;
        else if (lk.code == CMD_MODEL_LAST)
            rd_value = MODEL_LAST;
        else if (lk.code == CMD_FW_REVISIONS)
            rd_value = FW_REVS;
        else if (lk.code == CMD_FACTORY_LOC)
            rd_value[23:0] = factory_location;
        else if (lk.code == CMD_BUILD_DATE)
            rd_value = build_date;
        else if (lk.code == CMD_SERIAL_FIRST)
            rd_value = serial_number_first;
        else if (lk.code == CMD_SERIAL_LAST)
            rd_value = serial_number_last;
        else if (lk.code == CMD_UNIT_MULT)
            rd_value[15:0] = UNIT_MULTIPLIERS;
        else if (lk.code == CMD_STATE_WORD)
            rd_value[15:0] = system_state_word;
        else if (lk.code == CMD_SETTINGS)
            rd_value[15:0] = system_settings;
        else if (lk.code == CMD_FLOW_DIR)
            rd_value[7:0] = power_flow_direction;
        else if (lk.code == CMD_DISCHARGE_V_SET)
            rd_value[15:0] = discharge_voltage_setpoint;
        else if (lk.code == CMD_DISCHARGE_I_SET)
            rd_value[15:0] = discharge_current_setpoint;
        else if (lk.code == CMD_TWO_WAY_SETUP)
            rd_value[15:0] = two_way_mode_setup;
    end

    // reply frame; reads arriving while one is pending are dropped, no queue
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            tx_valid <= 1'b0;
            tx_ext   <= 1'b1;
            tx_id    <= '0;
            tx_dlc   <= '0;
            tx_data  <= '0;
        end
        else if (rd_fire)
        begin
            // writes never reach here, so they stay silent
            tx_valid <= 1'b1;
            tx_ext   <= 1'b1;
            tx_id    <= {ID_RSP_PREFIX, 2'b00, unit_addr};
            tx_dlc   <= DLC_CMD + lk.nbytes;
            tx_data  <= {keep_bytes(rd_value, lk.nbytes), lk.code};
        end
        else if (tx_valid && tx_ready)
            tx_valid <= 1'b0;
    end

    // millisecond enable for the store delay
    always_ff @(posedge sys_clk)
    begin
        if (rst || tick_cnt == 15'(TICK_LEN - 1))
            tick_cnt <= '0;
        else
            tick_cnt <= tick_cnt + 15'h0001;
        tick <= !rst && tick_cnt == 15'(TICK_LEN - 1);
    end

    assign nv_limit = system_settings[CFG_NV_DLY_LSB +: 2] == NV_DLY_10MIN
                      ? 20'(NV_10MIN_MS) : 20'(NV_1MIN_MS);

    // setpoints obey the storage settings, other writes commit at once
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            nv_save    <= 1'b0;
            nv_pending <= 1'b0;
            nv_ms      <= '0;
        end
        else
        begin
            nv_save <= 1'b0;
            if (wr_fire && !lk.nv_gated)
                nv_save <= 1'b1;
            else if (wr_fire && !system_settings[CFG_NV_OFF_BIT])
            begin
                // any fresh change restarts the quiet period
                if (system_settings[CFG_NV_DLY_LSB +: 2] == NV_DLY_1MIN
                    || system_settings[CFG_NV_DLY_LSB +: 2] == NV_DLY_10MIN)
                begin
                    nv_pending <= 1'b1;
                    nv_ms      <= '0;
                end
                else
                    nv_save <= 1'b1;
            end
            else if (nv_pending && system_settings[CFG_NV_OFF_BIT])
                nv_pending <= 1'b0;
            else if (nv_pending && tick)
            begin
                if (nv_ms >= nv_limit - 20'h00001)
                begin
                    nv_save    <= 1'b1;
                    nv_pending <= 1'b0;
                end
                else
                    nv_ms <= nv_ms + 20'h00001;
            end
        end
    end
endmodule

// ---- dv/cbd_can_sink.sv ----
`timescale 1ns/1ps
module cbd_can_sink (
    // clock and stall mode
    input  wire logic sys_clk,
    input  wire logic slow,
    // accept toward the decoder
    output logic      tx_ready
);
    int seed = 32'h4b724f80;
    initial tx_ready = 1'b0;
    // random stalls make a pending reply hold its frame
    always @(posedge sys_clk) tx_ready <= #1 slow ? 1'($random(seed)) : 1'b1;
endmodule

// ---- dv/cbd_checker_asserts.sv ----
`timescale 1ns/1ps
module cbd_checker (
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        rst,
    // request side
    input wire logic [5:0]  unit_addr,
    input wire logic        rx_valid,
    input wire logic        rx_ext,
    input wire logic [28:0] rx_id,
    input wire logic [3:0]  rx_dlc,
    input wire logic [63:0] rx_data,
    // reply side and stored value
    input wire logic        tx_valid,
    input wire logic        tx_ready,
    input wire logic        tx_ext,
    input wire logic [28:0] tx_id,
    input wire logic [63:0] tx_data,
    input wire logic [7:0]  power_flow_direction
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    wire rq = rx_valid && !tx_valid;
    wire me = rx_ext && rx_id == {21'h000c03, 2'b00, unit_addr};
    chk_read_reply: assert property (rq && me && rx_dlc == 4'h2 && rx_data[15:0] == 16'h0060
        |=> tx_valid && tx_data[15:0] == 16'h0060) else $error("read got no reply");
    chk_reply_id: assert property (tx_valid |-> tx_id == {21'h000c02, 2'b00, unit_addr})
        else $error("reply id wrong");
    chk_ext_frame: assert property (tx_ext) else $error("reply not extended");
    chk_reply_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("reply dropped early");
    chk_reply_drop: assert property (tx_valid && tx_ready |=> !tx_valid)
        else $error("reply not released");
    chk_write_silent: assert property (rq && rx_dlc != 4'h2 |=> !tx_valid)
        else $error("write answered");
    chk_unknown_code: assert property (rq && rx_data[15:0] == 16'h0041 |=> !tx_valid)
        else $error("unknown code answered");
    chk_base_frame: assert property (rq && !rx_ext |=> !tx_valid)
        else $error("base frame answered");
    chk_dir_set: assert property (rx_valid && me && rx_dlc == 4'h3 && rx_data[23:0] == 24'h010100
        |=> power_flow_direction == 8'h01) else $error("direction not stored");
    cover property (rq && me ##1 tx_valid);
    cover property (tx_valid && !tx_ready);
    cover property (rx_valid && !rx_ext);
endmodule
bind cbd_decoder cbd_checker chk (.*);

// ---- dv/tb_top.sv ----
`timescale 1ns/1ps
`define CHK(a,b) begin num_checks++; if ((a) !== (b)) mism(68'(a), 68'(b)); end
module tb_top;
    import cbd_pkg::*;
    logic sys_clk = 1'b0, rst = 1'b1, slow = 1'b0, rx_valid = 1'b0, rx_ext = 1'b1;
    logic [5:0] unit_addr = 6'h05;
    logic [28:0] rx_id = 29'h0, tx_id;
    logic [3:0] rx_dlc = 4'h0, tx_dlc;
    logic [63:0] rx_data = 64'h0, tx_data;
    logic [8:0] flt = 9'h0;
    logic [15:0] ms [7];
    logic tx_valid, tx_ready, tx_ext, nv_save;
    logic [7:0] output_on_off, power_flow_direction;
    logic [15:0] charge_voltage_setpoint, charge_current_setpoint, system_settings;
    logic [15:0] discharge_voltage_setpoint, discharge_current_setpoint, two_way_mode_setup;
    logic [23:0] factory_location;
    logic [47:0] build_date, serial_number_first, serial_number_last, v;
    logic [47:0] ids [5] = '{ID_MAKER_FIRST, ID_MAKER_LAST, ID_MODEL_FIRST, ID_MODEL_LAST, ID_FW_REVS};
    logic [67:0] e, q [$];
    logic [47:0] m [int];
    int err_total = 0, num_checks = 0, seed = 32'h4b724f80;
    int wr [12] = '{0, 'h20, 'h30, 'h85, 'h86, 'h87, 'h88, 'hc2, 'h100, 'h120, 'h130, 'h140};
    int sc [7] = '{'h50, 'h60, 'h61, 'h62, 'h70, 'h71, 'hc1};
    always #20 sys_clk = ~sys_clk;
    cbd_decoder #(.TICK_LEN(4), .NV_1MIN_MS(3), .NV_10MIN_MS(5)) dut (.*,
        .fan_locked(flt[0]), .over_temp(flt[1]), .dc_overvoltage_flag(flt[2]),
        .dc_overcurrent_flag(flt[3]), .short_circuit(flt[4]), .ac_range_fault_flag(flt[5]),
        .dc_output_off_flag(flt[6]), .high_temperature_alarm(flt[7]),
        .hv_side_overvoltage_flag(flt[8]), .ac_voltage_in(ms[0]), .dc_voltage_in(ms[1]),
        .dc_current_in(ms[2]), .ambient_temp_in(ms[3]), .fan1_speed_in(ms[4]),
        .fan2_speed_in(ms[5]), .system_state_in(ms[6]));
    cbd_can_sink sink (.sys_clk(sys_clk), .slow(slow), .tx_ready(tx_ready));
    function automatic int ln(int c);
        return c == 0 || c == 'h100 ? 1 : c == 'h85 ? 3 : c >= 'h80 && c <= 'h88 ? 6 : 2;
    endfunction
    function automatic logic [47:0] mk(int c);
        return (48'h1 << (8 * ln(c))) - 48'h1;
    endfunction
    task automatic mism(logic [67:0] g, logic [67:0] x);
        err_total++;
        $display("mismatch t=%0t got=%h exp=%h", $time, g, x);
    endtask
    task automatic stop_test;
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic frame(int c, int n, logic [47:0] d, bit bc = 0);
        @(posedge sys_clk);
        #1;
        rx_valid = 1'b1;
        rx_id = {21'h000c03, bc ? 8'hff : {2'b00, unit_addr}};
        rx_dlc = 4'(2 + n);
        rx_data = {d & mk(c), 16'(c)};
        @(posedge sys_clk);
        #1;
        rx_valid = 1'b0;
    endtask
    // unanswered reads surface here instead of hanging the run
    task automatic rd(int c, bit bc = 0);
        q.push_back({4'(2 + ln(c)), m[c], 16'(c)});
        frame(c, 0, 48'h0, bc);
        repeat (60) if (q.size() != 0) @(negedge sys_clk);
        if (q.size() != 0) mism(68'h0, q.pop_front());
    endtask
    task automatic wrt(int c, logic [47:0] d, bit u = 1);
        frame(c, ln(c), d);
        if (!(c inside {'h20, 'h30, 'h120, 'h130})) `CHK(nv_save, c inside {wr})
        if (u) m[c] = d & mk(c);
    endtask
    task automatic reset;
        rst = 1'b1;
        repeat (20) @(posedge sys_clk);
        #1;
        rst = 1'b0;
        foreach (wr[i]) m[wr[i]] = wr[i] inside {'h85, 'h86, 'h87, 'h88} ? RST_STR & mk(wr[i]) : 0;
        foreach (sc[i]) m[sc[i]] = 48'(ms[i]);
        foreach (ids[i]) m['h80 + i] = ids[i];
        m['hc0] = 48'(UNIT_MULTIPLIERS);
    endtask
    // an empty queue makes any stray reply a mismatch
    always @(posedge sys_clk) if (tx_valid === 1'b1 && tx_ready === 1'b1)
    begin
        e = q.size() != 0 ? q.pop_front() : 68'h0;
        `CHK({tx_dlc, tx_data}, e)
    end
    initial
    begin
        #400000;
        err_total++;
        stop_test;
    end
    initial
    begin
        foreach (ms[i]) ms[i] = 16'($random(seed));
        reset;
        foreach (wr[i]) rd(wr[i]);
        foreach (ids[i]) rd('h80 + i);
        foreach (sc[i]) rd(sc[i]);
        rd('hc0);
        $display("test reset values done");
        slow = 1'b1;
        foreach (wr[i])
        begin
            v = 48'({$random(seed), $random(seed)});
            wrt(wr[i], v, ln(wr[i]) > 1 || v[7:0] < 8'h02);
            rd(wr[i], i[0]);
        end
        `CHK(charge_voltage_setpoint, 16'(m['h20]))
        `CHK(charge_current_setpoint, 16'(m['h30]))
        `CHK(discharge_voltage_setpoint, 16'(m['h120]))
        `CHK(discharge_current_setpoint, 16'(m['h130]))
        `CHK({system_settings, two_way_mode_setup}, {16'(m['hc2]), 16'(m['h140])})
        `CHK(factory_location, 24'(m['h85]))
        `CHK(build_date, m['h86])
        `CHK(serial_number_first, m['h87])
        `CHK(serial_number_last, m['h88])
        for (int i = 0; i < 6; i++)
        begin
            wrt(i < 3 ? 0 : 'h100, 48'(i % 3), i % 3 < 2);
            rd(i < 3 ? 0 : 'h100);
            `CHK({output_on_off, power_flow_direction}, {8'(m[0]), 8'(m[256])})
        end
        $display("test write back done");
        wrt('h60, 48'h1234, 0);
        wrt('h41, 48'h1234, 0);
        frame('h41, 0, 48'h0);
        rx_ext = 1'b0;
        frame('h20, 0, 48'h0);
        rx_ext = 1'b1;
        rd('h60);
        for (int i = 0; i < 9; i++)
        begin
            flt = 9'h1 << i;
            m['h40] = 48'(flt);
            rd('h40);
        end
        $display("test refusals and faults done");
        unit_addr = 6'h2a;
        reset;
        rd('h20);
        $display("test second reset done");
        stop_test;
    end
endmodule
